// >>> core/sar_adc_pkg.sv
// shared constants and types for the converter sequencer
package sar_adc_pkg;

   // ==========================================================
   // widths and timing
   localparam int          ADDR_W    = 6;
   localparam int          DATA_W    = 16;
   localparam int          RES_W     = 10;
   localparam int          BUF_DEPTH = 16;
   localparam int          CONV_TADS = 12;
   localparam int          SYNC_TADS = 2;
   localparam logic [4:0]  CONV_LAST = 5'(CONV_TADS - 1);
   localparam logic [4:0]  SYNC_LAST = 5'(SYNC_TADS - 1);

   // ==========================================================
   // register offsets (word index)
   localparam logic [5:0]  OFF_CTRL1 = 6'h00;
   localparam logic [5:0]  OFF_CTRL2 = 6'h01;
   localparam logic [5:0]  OFF_CTRL3 = 6'h02;
   localparam logic [5:0]  OFF_SCAN  = 6'h03;
   localparam logic [5:0]  OFF_BUF   = 6'h10;
   localparam logic [15:0] CTRL_RST  = 16'h0000;

   // ==========================================================
   // field positions
   localparam int C1_ON   = 15;
   localparam int C1_FMT  = 8;
   localparam int C1_TRIG = 5;
   localparam int C1_SIM  = 3;
   localparam int C1_IRQ  = 2;
   localparam int C1_SAMPLE_CONTROL_BIT = 1;
   localparam int C1_DONE = 0;
   localparam int C2_SCAN = 10;
   localparam int C2_CHANNEL_COUNT_SEL = 8;
   localparam int C2_HALF = 7;
   localparam int C2_SAMPLES_PER_IRQ = 2;
   localparam int C2_BUFFER_SPLIT_SEL = 1;
   localparam int C2_ALTERNATE_INPUT_SEL = 0;
   localparam int C3_AUTO_SAMPLE_TIME = 8;
   localparam int C3_RC   = 7;
   localparam int C3_DIV  = 0;
   localparam logic [15:0] C1_WMASK = 16'h83EF;
   localparam logic [15:0] C2_WMASK = 16'h073F;
   localparam logic [15:0] C3_WMASK = 16'h1FBF;

   // ==========================================================
   // trigger source codes
   localparam logic [2:0] TRIG_SW   = 3'h0;
   localparam logic [2:0] TRIG_EXT  = 3'h1;
   localparam logic [2:0] TRIG_TMR  = 3'h2;
   localparam logic [2:0] TRIG_PWM  = 3'h3;
   localparam logic [2:0] TRIG_AUTO = 3'h7;

   typedef struct packed {
      logic [5:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   typedef struct packed {
      logic timer;
      logic pwm;
      logic ext;
   } trig_in_type;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_SYNC, ST_CONVERT} sar_state_type;

endpackage

// >>> core/sar_adc_sequencer.sv
// sequencing, trigger, clock and result buffer logic of the converter
// Notes on behaviour
// - sixteen 10-bit results, read formatted, write-proof
// - sample bit starts sampling, trigger starts conversion
// - each result buffered; flags after programmed count
// - sequential or simultaneous sampling of channels
// - channel count selects 1, 2 or 4
// - sequences per interrupt from 1 to 16
// - split buffer alternates halves per interrupt
// - per-interrupt field at bits 5:2
// - alternate input sets swap each sequence
// - channel zero scans mask inputs upward
// - trigger code 000: clearing sample bit converts
// - trigger code 111: convert after sample time
// - five trigger sources selectable
// - non-auto triggers get synchronising clocks
// - auto trigger, time 1: 13 clocks total
// - module-off aborts, partial result discarded
// - module-off beats a simultaneous auto start
// - after abort restart the aborted channel, or the group from channel 0 when simultaneous
// - twelve-clock conversion, divided clock
// - rc select takes the rc clock
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
module sar_adc_sequencer (
   input  wire logic                      sys_clk,      // 20 MHz system clock
   input  wire logic                      rst_b,        // async reset, active low
   input  wire sar_adc_pkg::reg_req_type  bus_req,      // register request
   output logic [15:0]                    rd_data,      // read data, one cycle later
   input  wire sar_adc_pkg::trig_in_type  trig,         // external trigger pulses
   input  wire logic                      rc_tick,      // rc oscillator tick pulse
   input  wire logic [9:0]                adc_result,   // converter result
   output logic [3:0]                     sample_hold,  // holds in acquisition
   output logic                           conv_busy,    // conversion in progress
   output logic [1:0]                     conv_channel, // channel being converted
   output logic                           use_set_b,    // input set b selected
   output logic [3:0]                     ch0_input,    // scanned channel zero input
   output logic                           irq_flag,     // conversion irq flag
   output logic                           done          // done bit
);
   import sar_adc_pkg::*;

   // ==========================================================
   // decode helpers
   function automatic logic [2:0] chan_count(input logic [1:0] sel);
      unique case (sel)
         2'b00:   chan_count = 3'd1;
         2'b01:   chan_count = 3'd2;
         default: chan_count = 3'd4;
      endcase
   endfunction

   function automatic logic [15:0] fmt(input logic [9:0] v, input logic [1:0] f);
      unique case (f)
         2'b00: fmt = {6'h00, v};
         2'b01: fmt = {{7{~v[9]}}, v[8:0]};
         2'b10: fmt = {v, 6'h00};
         2'b11: fmt = {~v[9], v[8:0], 6'h00};
      endcase
   endfunction

   function automatic logic [3:0] next_scan(input logic [15:0] m, input logic [3:0] p);
      logic hit;
      hit = 1'b0;
      next_scan = 4'h0;
      for (int i = 0; i < 16; i++)
      begin
         if (!hit && m[i] && (i >= int'(p)))
         begin
            next_scan = 4'(i);
            hit = 1'b1;
         end
      end
   endfunction

   // ==========================================================
   // control registers
   logic [15:0]   c1_q, c2_q, c3_q, scan_q;
   logic [9:0]    buf_q [BUF_DEPTH];
   sar_state_type state_q;
   logic [4:0]    cnt_q;
   logic [1:0]    ch_idx_q;
   logic [3:0]    seq_cnt_q, wr_ptr_q, scan_pos_q;
   logic          half_q, alt_q, tad_tick;
   logic          trig_fire, seq_irq, conv_done;

   logic wr1, wr2, wr3, wrs;
   assign wr1 = bus_req.wr && bus_req.addr == OFF_CTRL1;
   assign wr2 = bus_req.wr && bus_req.addr == OFF_CTRL2;
   assign wr3 = bus_req.wr && bus_req.addr == OFF_CTRL3;
   assign wrs = bus_req.wr && bus_req.addr == OFF_SCAN;

   logic       on_eff, sample_control_bit, sim, buffer_split_sel, alternate_input_sel, scan_en, rc_sel;
   logic [2:0] src, nch;
   logic [3:0] samples_per_irq;
   logic [4:0] auto_sample_time;
   logic [5:0] div;
   // a clearing write of module_on acts in its own cycle
   assign on_eff  = wr1 ? bus_req.wdata[C1_ON] : c1_q[C1_ON];
   assign sample_control_bit    = c1_q[C1_SAMPLE_CONTROL_BIT];
   assign sim     = c1_q[C1_SIM];
   assign src     = c1_q[C1_TRIG +: 3];
   assign samples_per_irq    = c2_q[C2_SAMPLES_PER_IRQ +: 4];
   assign buffer_split_sel    = c2_q[C2_BUFFER_SPLIT_SEL];
   assign alternate_input_sel    = c2_q[C2_ALTERNATE_INPUT_SEL];
   assign scan_en = c2_q[C2_SCAN];
   assign nch     = chan_count(c2_q[C2_CHANNEL_COUNT_SEL +: 2]);
   assign auto_sample_time    = c3_q[C3_AUTO_SAMPLE_TIME +: 5];
   assign rc_sel  = c3_q[C3_RC];
   assign div     = c3_q[C3_DIV +: 6];

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         c1_q <= CTRL_RST;
      else
      begin
         if (wr1)
            c1_q <= bus_req.wdata & C1_WMASK;
         if (trig_fire)
            c1_q[C1_SAMPLE_CONTROL_BIT] <= 1'b0;
         if (wr1 && !bus_req.wdata[C1_ON])
            c1_q[C1_SAMPLE_CONTROL_BIT] <= 1'b0;
         // flags set after count, set wins
         if (seq_irq)
         begin
            c1_q[C1_IRQ]  <= 1'b1;
            c1_q[C1_DONE] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         c2_q   <= CTRL_RST;
         c3_q   <= CTRL_RST;
         scan_q <= CTRL_RST;
      end
      else
      begin
         if (wr2)
            c2_q <= bus_req.wdata & C2_WMASK;
         if (wr3)
            c3_q <= bus_req.wdata & C3_WMASK;
         if (wrs)
            scan_q <= bus_req.wdata;
      end
   end

   // ==========================================================
   // register read port
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data <= 16'h0000;
      else if (bus_req.rd)
      begin
         if (bus_req.addr[5:4] == OFF_BUF[5:4])
            rd_data <= fmt(buf_q[bus_req.addr[3:0]], c1_q[C1_FMT +: 2]);
         else if (bus_req.addr == OFF_CTRL1)
            rd_data <= c1_q;
         else if (bus_req.addr == OFF_CTRL2)
            rd_data <= c2_q | (16'(half_q) << C2_HALF);
         else if (bus_req.addr == OFF_CTRL3)
            rd_data <= c3_q;
         else if (bus_req.addr == OFF_SCAN)
            rd_data <= scan_q;
         else
            rd_data <= 16'h0000;
      end
   end

   // ==========================================================
   // conversion clock
   logic [6:0] acc_q, lim, sum, rem;
   logic       div_tick;
   // period is half a cycle times divider plus one
   assign lim      = {1'b0, div} + 7'd1;
   assign sum      = acc_q + 7'd2;
   assign div_tick = sum >= lim;
   assign rem      = sum - lim;
   assign tad_tick = rc_sel ? rc_tick : div_tick;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         acc_q <= 7'd0;
      else if (!c1_q[C1_ON])
         acc_q <= 7'd0;
      else if (div_tick)
         acc_q <= (rem >= lim) ? 7'd0 : rem;
      else
         acc_q <= sum;
   end

   // ==========================================================
   // sequencer
   logic trig_hit, last_ch, seq_end, go_auto, ext_ev;
   assign last_ch = {1'b0, ch_idx_q} == nch - 3'd1;

   always_comb
   begin
      ext_ev = 1'b0;
      unique case (src)
         TRIG_SW:  ext_ev = !sample_control_bit;
         TRIG_EXT: ext_ev = trig.ext;
         TRIG_TMR: ext_ev = trig.timer;
         TRIG_PWM: ext_ev = trig.pwm;
         default:  ext_ev = 1'b0;
      endcase
   end

   assign go_auto   = src == TRIG_AUTO && tad_tick && (cnt_q + 5'd1) >= auto_sample_time;
   // software trigger is the falling sample bit
   assign trig_hit  = go_auto || (src != TRIG_AUTO && ext_ev);
   assign trig_fire = state_q == ST_SAMPLE && trig_hit && on_eff;
   assign conv_done = state_q == ST_CONVERT && tad_tick && cnt_q == CONV_LAST && on_eff;
   assign seq_end   = conv_done && last_ch;
   // interrupt after samples_per_irq plus one sequences
   assign seq_irq   = seq_end && seq_cnt_q == samples_per_irq;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'd0;
      end
      else if (!on_eff)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'd0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (sample_control_bit)
               begin
                  state_q <= ST_SAMPLE;
                  cnt_q   <= 5'd0;
               end
            ST_SAMPLE:
               if (trig_fire)
               begin
                  state_q <= go_auto ? ST_CONVERT : ST_SYNC;
                  cnt_q   <= 5'd0;
               end
               else if (tad_tick && cnt_q != 5'h1F)
                  cnt_q <= cnt_q + 5'd1;
            ST_SYNC:
               if (tad_tick && cnt_q == SYNC_LAST)
               begin
                  state_q <= ST_CONVERT;
                  cnt_q   <= 5'd0;
               end
               else if (tad_tick)
                  cnt_q <= cnt_q + 5'd1;
            ST_CONVERT:
               if (conv_done)
               begin
                  state_q <= (sim && !last_ch) ? ST_CONVERT : ST_IDLE;
                  cnt_q   <= 5'd0;
               end
               else if (tad_tick)
                  cnt_q <= cnt_q + 5'd1;
         endcase
      end
   end

   // ==========================================================
   // channel, sequence and pointer tracking
   logic       aborting;
   logic [3:0] base_next;
   assign aborting  = !on_eff && state_q != ST_IDLE;
   assign base_next = (buffer_split_sel && !half_q) ? 4'h8 : 4'h0;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ch_idx_q  <= 2'd0;
         seq_cnt_q <= 4'd0;
         wr_ptr_q  <= 4'd0;
         half_q    <= 1'b0;
         alt_q     <= 1'b0;
      end
      else if (conv_done)
      begin
         ch_idx_q <= last_ch ? 2'd0 : ch_idx_q + 2'd1;
         wr_ptr_q <= seq_irq ? base_next : wr_ptr_q + 4'd1;
         if (seq_irq)
         begin
            seq_cnt_q <= 4'd0;
            half_q    <= buffer_split_sel ? !half_q : 1'b0;
         end
         else if (seq_end)
            seq_cnt_q <= seq_cnt_q + 4'd1;
         if (seq_end)
            alt_q <= alternate_input_sel ? !alt_q : 1'b0;
      end
      else if (aborting && state_q != ST_SAMPLE && sim)
         ch_idx_q <= 2'd0;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         scan_pos_q <= 4'd0;
      else if (seq_irq)
         scan_pos_q <= 4'd0;
      else if (conv_done && ch_idx_q == 2'd0 && scan_en)
         scan_pos_q <= ch0_input + 4'd1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (conv_done)
         buf_q[wr_ptr_q] <= adc_result;
   end

   // ==========================================================
   // outputs
   logic [3:0] grp_mask;
   assign grp_mask     = 4'((5'd1 << nch) - 5'd1);
   assign sample_hold  = state_q != ST_SAMPLE ? 4'h0 :
                         sim ? grp_mask : 4'(4'h1 << ch_idx_q);
   assign conv_busy    = state_q == ST_CONVERT;
   assign conv_channel = ch_idx_q;
   assign use_set_b    = alternate_input_sel && alt_q;
   assign ch0_input    = scan_en ? next_scan(scan_q, scan_pos_q) : 4'h0;
   assign irq_flag     = c1_q[C1_IRQ];
   assign done         = c1_q[C1_DONE];

   // ==========================================================
   // checks
   // write pointer moves only on a finished conversion
   property p_buf_ro;
      @(posedge sys_clk) disable iff (!rst_b)
      !conv_done |=> wr_ptr_q == $past(wr_ptr_q);
   endproperty
   a_buf_ro: assert property (p_buf_ro) else $error("buffer changed");

   property p_irq_cause;
      @(posedge sys_clk) disable iff (!rst_b)
      $rose(irq_flag) |-> $past(seq_irq) && $past(seq_cnt_q) == $past(samples_per_irq);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without count");

   property p_sw_trig;
      @(posedge sys_clk) disable iff (!rst_b)
      state_q == ST_SAMPLE && src == TRIG_SW && !sample_control_bit && on_eff |=> state_q == ST_SYNC;
   endproperty
   a_sw_trig: assert property (p_sw_trig) else $error("sw trigger missed");

   property p_sync_len;
      @(posedge sys_clk) disable iff (!rst_b)
      state_q == ST_SAMPLE ##1 state_q == ST_SYNC |-> cnt_q == 5'd0;
   endproperty
   a_sync_len: assert property (p_sync_len) else $error("sync count bad");

   property p_abort;
      @(posedge sys_clk) disable iff (!rst_b)
      wr1 && !bus_req.wdata[C1_ON] |=> state_q == ST_IDLE && !sample_control_bit;
   endproperty
   a_abort: assert property (p_abort) else $error("abort ignored");

   property p_no_partial;
      @(posedge sys_clk) disable iff (!rst_b)
      conv_done |-> cnt_q == CONV_LAST && state_q == ST_CONVERT;
   endproperty
   a_no_partial: assert property (p_no_partial) else $error("early result");

   property p_auto_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      state_q == ST_SAMPLE && go_auto && !on_eff |=> state_q == ST_IDLE;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("start beat off");

   property p_rewind;
      @(posedge sys_clk) disable iff (!rst_b)
      seq_irq |=> wr_ptr_q == (buffer_split_sel ? {half_q, 3'b000} : 4'h0) && seq_cnt_q == 4'd0;
   endproperty
   a_rewind: assert property (p_rewind) else $error("pointer not rewound");

   property p_split_half;
      @(posedge sys_clk) disable iff (!rst_b)
      conv_done && buffer_split_sel |-> wr_ptr_q[3] == half_q;
   endproperty
   a_split_half: assert property (p_split_half) else $error("wrong half");

endmodule // sar_adc_sequencer

// >>> test/sar_adc_sequencer_tb_top.sv
// self-checking bench for the converter sequencer with a buffer model
`timescale 1ns/1ns
module sar_adc_sequencer_tb_top;
   import sar_adc_pkg::*;
   // ==========================================================
   // stimulus, observation and model state
   logic          sys_clk    = 1'b0;
   logic          rst_b      = 1'b0;
   reg_req_type   bus_req    = '0;
   trig_in_type   trig       = '0;
   logic          rc_tick    = 1'b0;
   logic          rc_en      = 1'b0;
   logic [9:0]    adc_result = '0;
   logic [15:0]   rd_data;
   logic [3:0]    sample_hold, ch0_input, sh_seen, in_seen;
   logic [1:0]    conv_channel, ch_seen;
   logic          conv_busy, use_set_b, irq_flag, done, b_seen;
   logic [31:0]   rng        = 32'd11328;
   logic [2:0]    tl [4]     = '{TRIG_SW, TRIG_EXT, TRIG_TMR, TRIG_PWM};
   logic [3:0]    se [4]     = '{4'h1, 4'h5, 4'h8, 4'h1};
   int            bad_count  = 0;
   int            checks_done = 0;
   int            mbuf [16];
   int            ptr = 0, seq = 0, ch = 0, half = 0, samples_per_irq, nch, split, exp_irq;
   int            n_busy, n_act, n_sync;

   sar_adc_sequencer sar_adc_sequencer_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .bus_req(bus_req), .rd_data(rd_data), .trig(trig), .rc_tick(rc_tick),
      .adc_result(adc_result), .sample_hold(sample_hold), .conv_busy(conv_busy),
      .conv_channel(conv_channel), .use_set_b(use_set_b), .ch0_input(ch0_input),
      .irq_flag(irq_flag), .done(done));

   // ==========================================================
   // clock, random source and common tasks
   always #25 sys_clk = ~sys_clk;

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   always @(posedge sys_clk)
   begin
      logic [31:0] r;
      r = xs();
      rc_tick <= rc_en & r[0];
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want)
      begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic fin(input string s);
      $display("test %s finished, mismatches %0d", s, bad_count);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
      if (a == OFF_CTRL1) exp_irq = 0;
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [15:0] want);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 check(rd_data, want);
   endtask

   task automatic bufchk(input int n);
      for (int i = 0; i < n; i++) rdchk(6'(OFF_BUF + i), 16'(mbuf[i]));
   endtask

   task automatic cfg(input logic [15:0] c2, input logic [15:0] c3);
      wr(OFF_CTRL1, 16'h0000);
      wr(OFF_CTRL2, c2);
      wr(OFF_CTRL3, c3);
      samples_per_irq = c2[5:2];
      split = c2[1];
      nch = c2[9] ? 4 : (c2[8] ? 2 : 1);
   endtask

   // one sample plus conversion run, optionally aborted in mid-conversion
   task automatic conv(input logic [2:0] t, input logic sim, input logic abort);
      int v, idle, k;
      v = int'(xs() % 32'd1024);
      adc_result <= 10'(v);
      n_busy = 0; n_act = 0; n_sync = 0; idle = 0; sh_seen = 4'h0;
      wr(OFF_CTRL1, 16'h8002 | (16'(t) << 5) | (16'(sim) << 3));
      if (t != TRIG_AUTO)
      begin
         repeat (4) @(posedge sys_clk);
         #1 check(16'({conv_busy, |sample_hold}), 16'h0001);
         sh_seen = sample_hold;
         if (t == TRIG_SW)
            wr(OFF_CTRL1, 16'h8000);
         else
         begin
            @(posedge sys_clk);
            trig <= '{timer: t == TRIG_TMR, pwm: t == TRIG_PWM, ext: t == TRIG_EXT};
            @(posedge sys_clk);
            trig <= '0;
         end
      end
      for (k = 0; k < 3000 && idle < 4; k++)
      begin
         #1;
         if (sample_hold != 0 && sh_seen == 0)
         begin
            sh_seen = sample_hold;
            b_seen = use_set_b;
            in_seen = ch0_input;
         end
         if (conv_busy && n_busy == 0) ch_seen = conv_channel;
         if (!conv_busy && n_busy == 0) n_sync++;
         n_busy += int'(conv_busy);
         n_act += int'(conv_busy | (|sample_hold));
         idle = (n_busy > 0 && !conv_busy && sample_hold == 0) ? idle + 1 : 0;
         if (abort && n_busy == 5)
         begin
            wr(OFF_CTRL1, 16'h0000);
            repeat (3) @(posedge sys_clk);
            #1 check(16'({conv_busy, sample_hold}), 16'h0000);
            break;
         end
         @(posedge sys_clk);
      end
      if (!abort && idle < 4)
      begin
         bad_count++;
         complete_run();
      end
      for (k = 0; k < (abort ? 0 : (sim ? nch : 1)); k++)
      begin
         mbuf[half * 8 * split + ptr] = v;
         ptr++;
         ch++;
         if (ch == nch)
         begin
            ch = 0;
            seq++;
         end
         if (ch == 0 && seq == samples_per_irq + 1)
         begin
            seq = 0;
            ptr = 0;
            exp_irq = 1;
            half ^= split;
         end
      end
      #1 check(16'({irq_flag, done}), 16'(exp_irq * 3));
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdchk(OFF_CTRL2, CTRL_RST);
      wr(OFF_CTRL3, 16'hFFFF);
      rdchk(OFF_CTRL3, C3_WMASK);
      rdchk(6'h3F, 16'h0000);
      fin("registers");
      cfg(16'h003C, 16'h0101);
      for (int k = 0; k < 16; k++)
      begin
         conv(TRIG_AUTO, 1'b0, 1'b0);
         check(16'(n_busy), 16'(CONV_TADS));
         check(16'(n_act), 16'd13);
      end
      bufchk(16);
      wr(OFF_BUF, 16'hFFFF);
      rdchk(OFF_BUF, 16'(mbuf[0]));
      fin("sixteen per interrupt");
      cfg(16'h001E, 16'h0101);
      for (int k = 0; k < 8; k++) conv(TRIG_AUTO, 1'b0, 1'b0);
      rdchk(OFF_CTRL2, 16'h009E);
      for (int k = 0; k < 8; k++) conv(TRIG_AUTO, 1'b0, 1'b0);
      bufchk(16);
      fin("split buffer");
      cfg(16'h0000, 16'h0103);
      conv(TRIG_AUTO, 1'b0, 1'b0);
      check(16'(n_busy), 16'(2 * CONV_TADS));
      cfg(16'h0004, 16'h0101);
      conv(TRIG_AUTO, 1'b0, 1'b1);
      rdchk(OFF_BUF, 16'(mbuf[0]));
      conv(TRIG_AUTO, 1'b0, 1'b0);
      conv(TRIG_AUTO, 1'b0, 1'b0);
      bufchk(2);
      fin("divider and abort");
      cfg(16'h0000, 16'h0101);
      for (int k = 0; k < 4; k++)
      begin
         conv(tl[k], 1'b0, 1'b0);
         check(16'(n_sync >= 2), 16'h0001);
         bufchk(1);
      end
      fin("trigger sources");
      for (int n = 2; n <= 4; n += 2)
      begin
         cfg((n == 4) ? 16'h0200 : 16'h0100, 16'h0101);
         for (int k = 0; k < n; k++)
         begin
            conv(TRIG_AUTO, 1'b0, 1'b0);
            check(16'(sh_seen), 16'(1 << k));
            check(16'(ch_seen), 16'(k));
         end
         conv(TRIG_AUTO, 1'b1, 1'b0);
         check(16'(sh_seen), 16'((1 << n) - 1));
         bufchk(n);
      end
      fin("channel groups");
      cfg(16'h0001, 16'h0101);
      for (int k = 0; k < 3; k++)
      begin
         conv(TRIG_AUTO, 1'b0, 1'b0);
         check(16'(b_seen), 16'(k % 2));
      end
      wr(OFF_SCAN, 16'h0122);
      cfg(16'h0408, 16'h0101);
      for (int k = 0; k < 4; k++)
      begin
         conv(TRIG_AUTO, 1'b0, 1'b0);
         check(16'(in_seen), 16'(se[k]));
      end
      fin("alternate and scan");
      cfg(16'h0000, 16'h0181);
      fork
         begin
            repeat (30) @(posedge sys_clk);
            #1 check(16'({conv_busy, sample_hold}), 16'h0001);
            rc_en <= 1'b1;
         end
      join_none
      conv(TRIG_AUTO, 1'b0, 1'b0);
      rc_en <= 1'b0;
      bufchk(1);
      fin("rc clock");
      wr(OFF_CTRL1, 16'h0100);
      rdchk(OFF_BUF, 16'(mbuf[0] - 512));
      wr(OFF_CTRL1, 16'h0200);
      rdchk(OFF_BUF, 16'(mbuf[0] << 6));
      wr(OFF_CTRL1, 16'h0300);
      rdchk(OFF_BUF, 16'((mbuf[0] - 512) << 6));
      fin("result formats");
      complete_run();
   end
endmodule // sar_adc_sequencer_tb_top
